// *** shared/sbfd_pkg.sv ***
/*
  Constants, operation codes and carrier types for the saturating and
  bit-field execute datapath. Assumes a 32-bit core and one core clock.
*/
package sbfd_pkg;

  localparam int          DATA_W      = 32;
  localparam int          BYTE_W      = 8;
  localparam int          HALF_W      = 16;
  localparam int          BYTE_LANES  = 4;
  localparam int          HALF_LANES  = 2;
  localparam int          SAT_BIT     = 27;
  localparam logic [31:0] FLAGS_MASK  = 32'hFF00_0000;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
  localparam logic [31:0] WORD_MAX    = 32'h7FFF_FFFF;
  localparam logic [31:0] WORD_MIN    = 32'h8000_0000;
  localparam logic [5:0]  CLZ_ALLZERO = 6'h20;

  typedef enum logic [4:0] {
    word_saturating_add,
    word_saturating_sub,
    doubling_saturating_add,
    doubling_saturating_sub,
    byte_lane_saturating_add,
    byte_lane_saturating_sub,
    half_lane_saturating_add,
    leading_zero_count,
    signed_clamp,
    unsigned_clamp,
    dual_signed_clamp,
    dual_unsigned_clamp,
    field_insert,
    field_clear,
    signed_field_extract,
    unsigned_field_extract,
    bit_order_mirror,
    word_byte_swap,
    halfword_byte_swap,
    low_half_byte_swap_signext
  } sbfd_op_t;

  typedef struct packed {
    logic        valid;
    sbfd_op_t    op;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] dest_old;
    logic [4:0]  field_lsb;
    logic [5:0]  field_width;
    logic [4:0]  sat_pos;
  } sbfd_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic        user_mode;
    logic        after_op;
  } sbfd_psw_wr_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic        sat;
  } sbfd_res_t;

endpackage

// *** hdl/sbfd_sat_lane.sv ***
/*
  One signed saturating add/subtract lane of parameter width.
  Purely combinational; the caller registers the outputs.
*/
`timescale 1ns/1ps
module sbfd_sat_lane #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] lhs,
  input  wire logic [W-1:0] rhs,
  input  wire logic         sub,
  output logic      [W-1:0] sum,
  output logic              sat
);
  logic [W:0] wide;

  always_comb begin
    wide = sub ? ({lhs[W-1], lhs} - {rhs[W-1], rhs}) : ({lhs[W-1], lhs} + {rhs[W-1], rhs});
    sat  = wide[W] ^ wide[W-1];
    // Sign of the wide sum picks the rail, never the wrapped value
    sum  = sat ? {wide[W], {(W-1){~wide[W]}}} : wide[W-1:0];
  end
endmodule // sbfd_sat_lane

// *** hdl/sbfd_datapath.sv ***
/*
  Saturating and bit-field execute datapath with the sticky saturation
  flag of the status word. Requests come from decode on sys_clk, one per
  cycle at most; results are registered one cycle later.
*/
// Behaviour
// - Overflow gives the rail value, never wrapped
// - Byte lanes saturate each on their own
// - Half lanes add and saturate independently
// - Any clamp sets the sticky flag
// - Flag holds until software writes zero
// - Doubling ops saturate double, then add/sub
// - Count zeros above the highest set bit
// - Clamp to power-of-two range, signed or unsigned
// - Dual clamps treat each halfword independently
// - Insert low source bits at given position
// - Clear a run of bits, keep others
// - Extract field, sign or zero extend
// - Mirror all 32 bits
// - Reverse the four bytes of a word
// - Swap bytes within each halfword
// - Swap low bytes, sign-extend the halfword
// - User writes touch flags only; reads see all
`timescale 1ns/1ps
module sbfd_datapath
  import sbfd_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire sbfd_pkg::sbfd_req_t    op_req,
  input  wire sbfd_pkg::sbfd_psw_wr_t psw_wr,
  output sbfd_pkg::sbfd_res_t         op_result,
  output logic [31:0]                 status_word
);
  import sbfd_pkg::*;

  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] b8_sum;
  logic [3:0]  b8_sat;
  logic [31:0] h16_sum;
  logic [1:0]  h16_sat;
  logic [31:0] dbl_val;
  logic        dbl_sat;
  logic [31:0] w_rhs;
  logic [31:0] w_sum;
  logic        w_sat;
  logic        w_sub;
  logic        is_dbl;
  logic [31:0] mirror;
  logic [31:0] res_val;
  logic        sat_now;
  logic [5:0]  clz_cnt;
  logic [31:0] fmask;
  logic [31:0] lowmask;
  logic [63:0] m64;
  logic [63:0] l64;
  logic [31:0] ext;
  logic [5:0]  sh;
  logic [32:0] cl_lo;
  logic [32:0] cl_hi;
  logic [31:0] wmask;
  sbfd_res_t   res_ff;
  sbfd_res_t   nxt_res;
  logic [31:0] status_ff;
  logic [31:0] nxt_status;

  assign a      = op_req.src_a;
  assign b      = op_req.src_b;
  assign is_dbl = (op_req.op == doubling_saturating_add) || (op_req.op == doubling_saturating_sub);
  assign w_sub  = (op_req.op == word_saturating_sub) || (op_req.op == doubling_saturating_sub);
  assign w_rhs  = is_dbl ? dbl_val : b;

  // Lanes are separate adders so no carry crosses a lane boundary
  for (genvar g = 0; g < BYTE_LANES; g++) begin : g_byte
    sbfd_sat_lane #(.W(BYTE_W)) u_lane (
      .lhs (a[g*BYTE_W +: BYTE_W]),
      .rhs (b[g*BYTE_W +: BYTE_W]),
      .sub (op_req.op == byte_lane_saturating_sub),
      .sum (b8_sum[g*BYTE_W +: BYTE_W]),
      .sat (b8_sat[g])
    );
  end

  for (genvar g = 0; g < HALF_LANES; g++) begin : g_half
    sbfd_sat_lane #(.W(HALF_W)) u_lane (
      .lhs (a[g*HALF_W +: HALF_W]),
      .rhs (b[g*HALF_W +: HALF_W]),
      .sub (1'b0),
      .sum (h16_sum[g*HALF_W +: HALF_W]),
      .sat (h16_sat[g])
    );
  end

  sbfd_sat_lane #(.W(DATA_W)) u_double (
    .lhs (b),
    .rhs (b),
    .sub (1'b0),
    .sum (dbl_val),
    .sat (dbl_sat)
  );

  sbfd_sat_lane #(.W(DATA_W)) u_word (
    .lhs (a),
    .rhs (w_rhs),
    .sub (w_sub),
    .sum (w_sum),
    .sat (w_sat)
  );

  for (genvar g = 0; g < DATA_W; g++) begin : g_mirror
    assign mirror[g] = a[DATA_W-1-g];
  end

  // Returns {clamped, value}; pos is n-1 for signed and n for unsigned
  function automatic logic [32:0] clamp_fn(input logic [31:0] v, input logic [4:0] pos,
                                           input logic uns);
    logic signed [33:0] sv;
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    sv = signed'({{2{v[31]}}, v});
    hi = (34'sh1 <<< pos) - 34'sh1;
    lo = uns ? 34'sh0 : -(34'sh1 <<< pos);
    if (sv > hi) begin
      clamp_fn = {1'b1, hi[31:0]};
    end else if (sv < lo) begin
      clamp_fn = {1'b1, lo[31:0]};
    end else begin
      clamp_fn = {1'b0, v};
    end
  endfunction

  always_comb begin
    clz_cnt = CLZ_ALLZERO;
    for (int i = 0; i < DATA_W; i++) begin
      if (a[i]) begin
        clz_cnt = 6'(DATA_W - 1 - i);
      end
    end
    m64     = ((64'h1 << op_req.field_width) - 64'h1) << op_req.field_lsb;
    l64     = (64'h1 << op_req.field_width) - 64'h1;
    fmask   = m64[31:0];
    lowmask = l64[31:0];
    ext     = (a >> op_req.field_lsb) & lowmask;
    sh      = 6'(DATA_W) - op_req.field_width;
    cl_lo   = '0;
    cl_hi   = '0;
    res_val = '0;
    sat_now = 1'b0;
    case (op_req.op)
      word_saturating_add, word_saturating_sub: begin
        res_val = w_sum;
        sat_now = w_sat;
      end
      doubling_saturating_add, doubling_saturating_sub: begin
        res_val = w_sum;
        sat_now = w_sat | dbl_sat;
      end
      byte_lane_saturating_add, byte_lane_saturating_sub: begin
        res_val = b8_sum;
        sat_now = |b8_sat;
      end
      half_lane_saturating_add: begin
        res_val = h16_sum;
        sat_now = |h16_sat;
      end
      leading_zero_count: begin
        res_val = {26'h0, clz_cnt};
      end
      signed_clamp, unsigned_clamp: begin
        cl_lo   = clamp_fn(a, op_req.sat_pos, op_req.op == unsigned_clamp);
        res_val = cl_lo[31:0];
        sat_now = cl_lo[32];
      end
      dual_signed_clamp, dual_unsigned_clamp: begin
        cl_lo   = clamp_fn({{16{a[15]}}, a[15:0]}, op_req.sat_pos,
                           op_req.op == dual_unsigned_clamp);
        cl_hi   = clamp_fn({{16{a[31]}}, a[31:16]}, op_req.sat_pos,
                           op_req.op == dual_unsigned_clamp);
        res_val = {cl_hi[15:0], cl_lo[15:0]};
        sat_now = cl_lo[32] | cl_hi[32];
      end
      field_insert: begin
        res_val = (op_req.dest_old & ~fmask) | ((a << op_req.field_lsb) & fmask);
      end
      field_clear: begin
        res_val = op_req.dest_old & ~fmask;
      end
      signed_field_extract: begin
        res_val = 32'($signed(ext << sh) >>> sh);
      end
      unsigned_field_extract: begin
        res_val = ext;
      end
      bit_order_mirror: begin
        res_val = mirror;
      end
      word_byte_swap: begin
        res_val = {a[7:0], a[15:8], a[23:16], a[31:24]};
      end
      halfword_byte_swap: begin
        res_val = {a[23:16], a[31:24], a[7:0], a[15:8]};
      end
      low_half_byte_swap_signext: begin
        res_val = {{16{a[7]}}, a[7:0], a[15:8]};
      end
      default: begin
        res_val = '0;
      end
    endcase
  end

  always_comb begin
    nxt_res.valid = op_req.valid;
    nxt_res.data  = op_req.valid ? res_val : res_ff.data;
    nxt_res.sat   = op_req.valid & sat_now;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      res_ff <= '0;
    end else begin
      res_ff <= nxt_res;
    end
  end

  // A write issued after the op in program order overrides its set
  always_comb begin
    wmask      = psw_wr.user_mode ? FLAGS_MASK : 32'hFFFF_FFFF;
    nxt_status = status_ff;
    if (psw_wr.valid) begin
      nxt_status = (status_ff & ~wmask) | (psw_wr.data & wmask);
    end
    if (op_req.valid && sat_now && !(psw_wr.valid && psw_wr.after_op)) begin
      nxt_status[SAT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign op_result   = res_ff;
  assign status_word = status_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_word_sat_max: assert property (
    op_req.valid && op_req.op == word_saturating_add && !a[31] && !b[31]
      && ({1'b0, a} + {1'b0, b}) > {1'b0, WORD_MAX}
    |=> res_ff.data == WORD_MAX && res_ff.sat
      && (status_ff[SAT_BIT] || ($past(psw_wr.valid) && $past(psw_wr.after_op))))
    else $error("word add overflow did not give the positive rail");
  a_byte_lane_sep: assert property (
    op_req.valid && op_req.op == byte_lane_saturating_add && a[7:0] == 8'h7F
      && b[7:0] == 8'h01 && a[15:8] == 8'h00 && b[15:8] == 8'h00
    |=> res_ff.data[7:0] == 8'h7F && res_ff.data[15:8] == 8'h00)
    else $error("byte lane saturation leaked or wrapped");
  a_half_lane_sep: assert property (
    op_req.valid && op_req.op == half_lane_saturating_add && a[15:0] == 16'h8000
      && b[15:0] == 16'h8000 && a[31:16] == 16'h0000 && b[31:16] == 16'h0000
    |=> res_ff.data == 32'h0000_8000)
    else $error("half lane saturation wrong");
  a_sat_sets_flag: assert property (
    op_req.valid && sat_now && !psw_wr.valid |=> status_ff[SAT_BIT] && res_ff.sat)
    else $error("clamp did not set the sticky flag");
  a_flag_sticky: assert property (
    status_ff[SAT_BIT] && !psw_wr.valid |=> status_ff[SAT_BIT])
    else $error("sticky flag dropped without a write");
  a_flag_no_spur: assert property (
    !status_ff[SAT_BIT] && !(op_req.valid && sat_now) && !psw_wr.valid
    |=> !status_ff[SAT_BIT])
    else $error("sticky flag set without a clamp");
  a_order_clear: assert property (
    op_req.valid && sat_now && psw_wr.valid && !psw_wr.data[SAT_BIT]
    |=> status_ff[SAT_BIT] == !$past(psw_wr.after_op))
    else $error("same-cycle flag update broke program order");
  a_double_sat: assert property (
    op_req.valid && op_req.op == doubling_saturating_add && a == 32'h0 && b == 32'h4000_0000
    |=> res_ff.data == WORD_MAX && res_ff.sat
      && (status_ff[SAT_BIT] || ($past(psw_wr.valid) && $past(psw_wr.after_op))))
    else $error("doubling add did not saturate the doubled operand");
  a_clz_count: assert property (
    op_req.valid && op_req.op == leading_zero_count && a == 32'h0000_0001
    |=> res_ff.data == 32'h0000_001F)
    else $error("leading zero count wrong");
  a_uclamp_neg: assert property (
    op_req.valid && op_req.op == unsigned_clamp && a[31] |=> res_ff.data == 32'h0 && res_ff.sat)
    else $error("unsigned clamp of negative value not zero");
  a_mirror_bits: assert property (
    op_req.valid && op_req.op == bit_order_mirror
    |=> res_ff.data[31] == $past(a[0]) && res_ff.data[0] == $past(a[31])
      && res_ff.data[16] == $past(a[15]) && res_ff.data[15] == $past(a[16]))
    else $error("bit mirror wrong");
  a_user_write: assert property (
    psw_wr.valid && psw_wr.user_mode && !(op_req.valid && sat_now)
    |=> (status_ff & ~FLAGS_MASK) == ($past(status_ff) & ~FLAGS_MASK))
    else $error("user write changed bits outside the flags field");

  c_word_sat: cover property (op_req.valid && op_req.op == word_saturating_sub && w_sat);
  c_byte_sat: cover property (op_req.valid && op_req.op == byte_lane_saturating_add && &b8_sat);
  c_collision: cover property (op_req.valid && sat_now && psw_wr.valid && psw_wr.after_op);
  c_extract: cover property (op_req.valid && op_req.op == signed_field_extract && ext[0]);
endmodule // sbfd_datapath

// *** testbench/sbfd_regfile_model.sv ***
/*
  Register file side of the datapath: takes each write-back.
  Assumes results come as one-cycle valid pulses on sys_clk.
*/
`timescale 1ns/1ps
module sbfd_regfile_model
  import sbfd_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire sbfd_pkg::sbfd_res_t op_result,
  output logic [31:0]              wb_data_ff
);
  // Writes only on valid, so a held data bus is never taken twice
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wb_data_ff <= 32'h0;
    end else if (op_result.valid) begin
      wb_data_ff <= op_result.data;
    end
  end
endmodule // sbfd_regfile_model

// *** testbench/test_saturating_bitfield_datapath.sv ***
/*
  Self-checking bench for the saturating and bit-field datapath.
  Assumes a 100 MHz sys_clk and inputs driven on the falling edge.
*/
`timescale 1ns/1ps
module test_saturating_bitfield_datapath;
  import sbfd_pkg::*;
  logic         sys_clk;
  logic         srst;
  sbfd_req_t    req;
  sbfd_psw_wr_t psw;
  sbfd_res_t    op_result;
  logic [31:0]  status_word;
  logic [31:0]  wb_data;
  int           failures;
  int           n_tests;
  int           cyc;

  sbfd_datapath i_sbfd_datapath (.sys_clk(sys_clk), .srst(srst), .op_req(req),
    .psw_wr(psw), .op_result(op_result), .status_word(status_word));
  sbfd_regfile_model i_sbfd_regfile_model (.sys_clk(sys_clk), .srst(srst),
    .op_result(op_result), .wb_data_ff(wb_data));

  always #5 sys_clk = ~sys_clk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 110 cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One op; result pulse checked one cycle on, then its end and write-back
  task automatic run(input sbfd_op_t op, input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] d, input logic [4:0] lsb, input logic [5:0] w,
                     input logic [4:0] p, input logic [31:0] e, input logic s);
    @(negedge sys_clk);
    req <= '{1'b1, op, a, b, d, lsb, w, p};
    @(negedge sys_clk);
    req.valid <= 1'b0;
    chk({31'h0, op_result.valid}, 32'h1);
    chk(op_result.data, e);
    chk({31'h0, op_result.sat}, {31'h0, s});
    @(negedge sys_clk);
    chk({31'h0, op_result.valid}, 32'h0);
    chk(wb_data, e);
  endtask

  task automatic wr(input logic [31:0] dt, input logic um);
    @(negedge sys_clk);
    psw <= '{1'b1, dt, um, 1'b0};
    @(negedge sys_clk);
    psw.valid <= 1'b0;
  endtask

  task automatic t_sat();
    run(word_saturating_add, WORD_MAX, 32'h1, 0, 0, 1, 0, WORD_MAX, 1'b1);
    run(word_saturating_sub, WORD_MIN, 32'h1, 0, 0, 1, 0, WORD_MIN, 1'b1);
    run(byte_lane_saturating_add, 32'h7F7F0180, 32'h01018080, 0, 0, 1, 0, 32'h7F7F8180, 1'b1);
    run(byte_lane_saturating_sub, 32'h807F0000, 32'h01FF0000, 0, 0, 1, 0, 32'h807F0000, 1'b1);
    run(byte_lane_saturating_add, 32'h0000007F, 32'h00000001, 0, 0, 1, 0, 32'h0000007F, 1'b1);
    run(half_lane_saturating_add, 32'h00008000, 32'h00008000, 0, 0, 1, 0, 32'h00008000, 1'b1);
    run(half_lane_saturating_add, 32'h7FFF0001, 32'h00010001, 0, 0, 1, 0, 32'h7FFF0002, 1'b1);
    run(doubling_saturating_add, 0, 32'h40000000, 0, 0, 1, 0, WORD_MAX, 1'b1);
    run(doubling_saturating_sub, 0, 32'h1, 0, 0, 1, 0, 32'hFFFFFFFE, 1'b0);
    run(doubling_saturating_sub, WORD_MIN, 32'h1, 0, 0, 1, 0, WORD_MIN, 1'b1);
    chk(status_word, 32'h08000000);
    $display("saturation test done");
  endtask

  task automatic t_bits();
    run(leading_zero_count, 32'h00010000, 0, 0, 0, 1, 0, 32'hF, 1'b0);
    run(leading_zero_count, 0, 0, 0, 0, 1, 0, 32'h20, 1'b0);
    run(leading_zero_count, 32'h00000001, 0, 0, 0, 1, 0, 32'h1F, 1'b0);
    run(signed_clamp, 32'h200, 0, 0, 0, 1, 7, 32'h7F, 1'b1);
    run(unsigned_clamp, 32'hFFFFFFFF, 0, 0, 0, 1, 8, 32'h0, 1'b1);
    run(dual_signed_clamp, 32'h0100FF00, 0, 0, 0, 1, 7, 32'h007FFF80, 1'b1);
    run(dual_unsigned_clamp, 32'h0100FFFF, 0, 0, 0, 1, 8, 32'h00FF0000, 1'b1);
    run(field_insert, 32'h5, 0, 32'hFFFFFFFF, 8, 4, 0, 32'hFFFFF5FF, 1'b0);
    run(field_clear, 0, 0, 32'hFFFFFFFF, 4, 8, 0, 32'hFFFFF00F, 1'b0);
    run(signed_field_extract, 32'hF00, 0, 0, 8, 4, 0, 32'hFFFFFFFF, 1'b0);
    run(unsigned_field_extract, 32'hF00, 0, 0, 8, 4, 0, 32'hF, 1'b0);
    run(bit_order_mirror, 32'h00000001, 0, 0, 0, 1, 0, 32'h80000000, 1'b0);
    run(word_byte_swap, 32'h12345678, 0, 0, 0, 1, 0, 32'h78563412, 1'b0);
    run(halfword_byte_swap, 32'h12345678, 0, 0, 0, 1, 0, 32'h34127856, 1'b0);
    run(low_half_byte_swap_signext, 32'h12345680, 0, 0, 0, 1, 0, 32'hFFFF8056, 1'b0);
    $display("bit-field test done");
  endtask

  task automatic t_flag();
    run(bit_order_mirror, 32'h1, 0, 0, 0, 1, 0, 32'h80000000, 1'b0);
    chk(status_word, 32'h08000000);
    wr(32'h0, 1'b0);
    chk(status_word, 32'h0);
    // Collision: a later write wins, an earlier one is overridden
    for (int ao = 0; ao < 2; ao++) begin
      @(negedge sys_clk);
      req <= '{1'b1, word_saturating_add, WORD_MAX, 32'h1, 32'h0, 5'h0, 6'h1, 5'h0};
      psw <= '{1'b1, 32'h0, 1'b0, ao[0]};
      @(negedge sys_clk);
      req.valid <= 1'b0;
      psw.valid <= 1'b0;
      chk(status_word, ao[0] ? 32'h0 : 32'h08000000);
    end
    wr(32'h00001234, 1'b0);
    wr(32'hFFFFFFFF, 1'b1);
    chk(status_word, 32'hFF001234);
    $display("flag test done");
  endtask

  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    req = '0;
    psw = '0;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(negedge sys_clk);
    srst <= 1'b0;
    chk(status_word, STATUS_RST);
    chk(op_result.data, 32'h0);
    t_sat();
    t_bits();
    t_flag();
    test_done();
  end
endmodule // test_saturating_bitfield_datapath
